// ===== design/pmt_timer.sv
// Periodic 8-bit match timer with prescaler, postscaler and APB register slave.
`timescale 1ns/1ps
`default_nettype none

module pmt_timer
  import pmt_pkg::*;
#(
  parameter int INSTR_DIV = PMT_INSTR_CYCLES
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output pmt_evt_t         timer_evt
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]  timer_count_reg;
  logic [7:0]  period_value_reg;
  pmt_ctrl_t   timer_control_reg;
  logic        match_irq_flag_reg;
  logic        match_irq_enable_reg;
  logic [3:0]  pre_cnt_reg;
  logic [3:0]  post_cnt_reg;
  logic [1:0]  instr_cnt_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        irq_reg;
  logic        match_pulse_reg;
  logic        shift_clk_reg;
  logic        instr_tick;
  logic        pre_tick;
  logic        is_match;
  logic        match_event;
  logic        post_done;
  logic        access;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_count;
  logic        wr_period;
  logic        wr_control;
  logic        wr_status;
  logic        wr_mask;
  logic        scaler_clear;
  logic [31:0] rdata_next;
  logic        addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Last prescale count for a select value
  function automatic logic [3:0] pre_last(input logic [1:0] sel);
    unique case (sel)
      PMT_PRE_DIV1: pre_last = PMT_PRE_LAST1;
      PMT_PRE_DIV4: pre_last = PMT_PRE_LAST4;
      default:      pre_last = PMT_PRE_LAST16;
    endcase
  endfunction : pre_last

  // Address decode, used for reads, writes and error
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
    addr_hit = (a == reg_addr);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, transfer completes on pready high
  assign access     = psel & penable;
  assign wr_fire    = access & pready_reg & pwrite;
  assign rd_fire    = access & pready_reg & ~pwrite;
  assign addr_ok    = addr_hit(paddr, PMT_COUNT_ADDR) | addr_hit(paddr, PMT_PERIOD_ADDR)
                    | addr_hit(paddr, PMT_CONTROL_ADDR) | addr_hit(paddr, PMT_STATUS_ADDR)
                    | addr_hit(paddr, PMT_MASK_ADDR);
  assign wr_count   = wr_fire & addr_hit(paddr, PMT_COUNT_ADDR);
  assign wr_period  = wr_fire & addr_hit(paddr, PMT_PERIOD_ADDR);
  assign wr_control = wr_fire & addr_hit(paddr, PMT_CONTROL_ADDR);
  assign wr_status  = wr_fire & addr_hit(paddr, PMT_STATUS_ADDR);
  assign wr_mask    = wr_fire & addr_hit(paddr, PMT_MASK_ADDR);

  // Ready rises one cycle into the access phase and drops after the edge
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~addr_ok;
    end
  end

  // Read mux; unused control bit and upper bits read zero
  always_comb
  begin
    rdata_next = PMT_RDATA_NONE;
    if (addr_hit(paddr, PMT_COUNT_ADDR))
      rdata_next[7:0] = timer_count_reg;
    else if (addr_hit(paddr, PMT_PERIOD_ADDR))
      rdata_next[7:0] = period_value_reg;
    else if (addr_hit(paddr, PMT_CONTROL_ADDR))
      rdata_next[7:0] = {1'b0, timer_control_reg};
    else if (addr_hit(paddr, PMT_STATUS_ADDR))
      rdata_next[PMT_FLAG_BIT] = match_irq_flag_reg;
    else if (addr_hit(paddr, PMT_MASK_ADDR))
      rdata_next[PMT_FLAG_BIT] = match_irq_enable_reg;
  end

  // Read data captured together with ready
  always_ff @(posedge core_clk)
  begin
    if (srst)
      prdata_reg <= PMT_RDATA_NONE;
    else if (access & ~pready_reg & ~pwrite)
      prdata_reg <= rdata_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction-cycle tick from the core clock
  always_ff @(posedge core_clk)
  begin
    if (srst)
      instr_cnt_reg <= 2'h0;
    else if (instr_tick)
      instr_cnt_reg <= 2'h0;
    else
      instr_cnt_reg <= instr_cnt_reg + 2'h1;
  end

  assign instr_tick = (instr_cnt_reg == 2'(INSTR_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and match detection
  assign scaler_clear = wr_count | wr_control;
  assign pre_tick     = instr_tick & timer_control_reg.timer_run_bit
                      & (pre_cnt_reg == pre_last(timer_control_reg.prescale_select));
  assign is_match     = (timer_count_reg == period_value_reg);
  assign match_event  = pre_tick & is_match & ~wr_count;
  assign post_done    = match_event
                      & (post_cnt_reg == timer_control_reg.postscale_select);

  // Prescale counter, cleared by count and control writes and reset
  always_ff @(posedge core_clk)
  begin
    if (srst || scaler_clear)
      pre_cnt_reg <= 4'h0;
    else if (instr_tick && timer_control_reg.timer_run_bit)
    begin
      if (pre_cnt_reg == pre_last(timer_control_reg.prescale_select))
        pre_cnt_reg <= 4'h0;
      else
        pre_cnt_reg <= pre_cnt_reg + 4'h1;
    end
  end

  // Timer counter; software write wins over a match in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
      timer_count_reg <= PMT_COUNT_RST;
    else if (wr_count)
      timer_count_reg <= pwdata[7:0];
    else if (match_event)
      timer_count_reg <= PMT_COUNT_RST;
    else if (pre_tick)
      timer_count_reg <= timer_count_reg + 8'h01;
  end

  // Period register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      period_value_reg <= PMT_PERIOD_RST;
    else if (wr_period)
      period_value_reg <= pwdata[7:0];
  end

  // Control register; bit 7 not stored, counter untouched here
  always_ff @(posedge core_clk)
  begin
    if (srst)
      timer_control_reg <= pmt_ctrl_t'(PMT_CONTROL_RST);
    else if (wr_control)
      timer_control_reg <= pmt_ctrl_t'(pwdata[6:0]);
  end

  // Postscale counter, advanced by each match
  always_ff @(posedge core_clk)
  begin
    if (srst || scaler_clear)
      post_cnt_reg <= 4'h0;
    else if (post_done)
      post_cnt_reg <= 4'h0;
    else if (match_event)
      post_cnt_reg <= post_cnt_reg + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flag, enable and output

  // Sticky flag: set wins over a read clear or a write of zero
  // A read clears only a flag that it returned, so a set after capture survives
  always_ff @(posedge core_clk)
  begin
    if (srst)
      match_irq_flag_reg <= 1'b0;
    else if (post_done)
      match_irq_flag_reg <= 1'b1;
    else if (rd_fire && addr_hit(paddr, PMT_STATUS_ADDR) && prdata_reg[PMT_FLAG_BIT])
      match_irq_flag_reg <= 1'b0;
    else if (wr_status && !pwdata[PMT_FLAG_BIT])
      match_irq_flag_reg <= 1'b0;
  end

  // Enable bit
  always_ff @(posedge core_clk)
  begin
    if (srst)
      match_irq_enable_reg <= 1'b0;
    else if (wr_mask)
      match_irq_enable_reg <= pwdata[PMT_FLAG_BIT];
  end

  // Level interrupt, registered
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq_reg <= 1'b0;
    else
      irq_reg <= match_irq_flag_reg & match_irq_enable_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer outputs to PWM units and serial port
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      match_pulse_reg <= 1'b0;
      shift_clk_reg   <= 1'b0;
    end
    else
    begin
      match_pulse_reg <= match_event;
      if (match_event)
        shift_clk_reg <= ~shift_clk_reg;
    end
  end

  // Ports straight from flip-flops
  assign prdata                = prdata_reg;
  assign pready                = pready_reg;
  assign pslverr               = pslverr_reg;
  assign irq                   = irq_reg;
  assign timer_evt             = '{match_pulse: match_pulse_reg, shift_clk: shift_clk_reg};

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // A write to count; count_wr_a checks that the data appears one cycle later
  sequence count_write_s;
    wr_count;
  endsequence

  sequence match_s;
    match_event;
  endsequence

  count_wr_a: assert property (count_write_s |=> timer_count_reg == $past(pwdata[7:0]))
    else $error("count write not stored");

  period_wr_a: assert property (wr_period |=> period_value_reg == $past(pwdata[7:0]))
    else $error("period write not stored");

  count_step_a: assert property (pre_tick && !is_match && !wr_count
                                 |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
    else $error("counter did not advance");

  count_hold_a: assert property (!pre_tick && !wr_count |=> $stable(timer_count_reg))
    else $error("counter moved without tick");

  pre_div16_a: assert property (timer_control_reg.prescale_select[1] && pre_tick
                                |-> pre_cnt_reg == 4'hF)
    else $error("divide by 16 tick early");

  pre_div4_a: assert property (timer_control_reg.prescale_select == 2'h1 && pre_tick
                               |-> pre_cnt_reg == 4'h3)
    else $error("divide by 4 tick wrong");

  match_clear_a: assert property (match_s |=> timer_count_reg == 8'h00)
    else $error("match did not clear counter");

  match_pulse_a: assert property (match_s
                                  |=> timer_evt.match_pulse && $changed(timer_evt.shift_clk))
    else $error("match outputs missing");

  scaler_clr_a: assert property (scaler_clear
                                 |=> pre_cnt_reg == 4'h0 && post_cnt_reg == 4'h0)
    else $error("scalers not cleared");

  ctrl_keep_a: assert property (wr_control && !pre_tick |=> $stable(timer_count_reg))
    else $error("control write moved counter");

  post_set_a: assert property (post_done |=> match_irq_flag_reg)
    else $error("postscaler did not set flag");

  irq_gate_a: assert property (!match_irq_enable_reg |=> !irq)
    else $error("interrupt while disabled");

  run_off_a: assert property (!timer_control_reg.timer_run_bit && !wr_count
                              |=> $stable(timer_count_reg))
    else $error("timer counted while off");

  ctrl_bit7_a: assert property (access && !pready_reg && !pwrite
                                && addr_hit(paddr, PMT_CONTROL_ADDR)
                                |=> prdata[PMT_CTRL_UNUSED] == 1'b0)
    else $error("control bit 7 read nonzero");

  flag_hold_a: assert property (match_irq_flag_reg && !rd_fire && !wr_status
                                |=> match_irq_flag_reg)
    else $error("flag cleared by itself");

  reset_val_a: assert property (@(posedge core_clk) disable iff (1'b0)
                                srst |=> timer_count_reg == 8'h00 && period_value_reg == 8'hFF)
    else $error("reset values wrong");

  cmp_a: assert property (pre_tick && (timer_count_reg == period_value_reg) && !wr_count
                          |=> timer_evt.match_pulse && timer_count_reg == 8'h00)
    else $error("equal values not matched");

  irq_raise_a: assert property (match_irq_flag_reg && match_irq_enable_reg |=> irq)
    else $error("interrupt not raised");

  flag_seen_a: assert property (match_irq_flag_reg && rd_fire && !prdata[PMT_FLAG_BIT]
                                && addr_hit(paddr, PMT_STATUS_ADDR)
                                |=> match_irq_flag_reg)
    else $error("unseen flag cleared by read");

  pre_div1_a: assert property (timer_control_reg.prescale_select == PMT_PRE_DIV1
                               && instr_tick && timer_control_reg.timer_run_bit
                               |-> pre_tick)
    else $error("divide by 1 tick missing");

  unmapped_err_a: assert property (access && !pready_reg && !addr_ok |=> pslverr && pready)
    else $error("unmapped access not refused");

endmodule : pmt_timer

`default_nettype wire

// ===== design/pmt_pkg.sv
// Package for the periodic match timer: register map, fields, reset values, timing.
package pmt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the APB bus
  localparam logic [7:0] PMT_COUNT_ADDR   = 8'h00;  // timer_count_byte
  localparam logic [7:0] PMT_PERIOD_ADDR  = 8'h04;  // period_compare_byte
  localparam logic [7:0] PMT_CONTROL_ADDR = 8'h08;  // timer_control_byte
  localparam logic [7:0] PMT_STATUS_ADDR  = 8'h0C;  // peripheral_irq_flags
  localparam logic [7:0] PMT_MASK_ADDR    = 8'h10;  // peripheral_irq_enables

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int          PMT_FLAG_BIT      = 0;      // match_irq_flag / match_irq_enable
  localparam int          PMT_CTRL_UNUSED   = 7;      // Always reads zero
  localparam logic [7:0]  PMT_COUNT_RST     = 8'h00;
  localparam logic [7:0]  PMT_PERIOD_RST    = 8'hFF;
  localparam logic [6:0]  PMT_CONTROL_RST   = 7'h00;
  localparam logic [31:0] PMT_RDATA_NONE    = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Prescale encodings and their last count
  localparam logic [1:0]  PMT_PRE_DIV1      = 2'h0;
  localparam logic [1:0]  PMT_PRE_DIV4      = 2'h1;
  localparam logic [3:0]  PMT_PRE_LAST1     = 4'h0;
  localparam logic [3:0]  PMT_PRE_LAST4     = 4'h3;
  localparam logic [3:0]  PMT_PRE_LAST16    = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: core clock is the oscillator, instruction cycle is four of it
  localparam int          PMT_CORE_PERIOD_NS = 4;
  localparam int          PMT_INSTR_DIV      = 4;
  localparam int          PMT_INSTR_NS       = PMT_CORE_PERIOD_NS * PMT_INSTR_DIV;
  localparam int          PMT_INSTR_CYCLES   = PMT_INSTR_NS / PMT_CORE_PERIOD_NS;

  // Control register layout, bit 7 left out
  typedef struct packed {
    logic [3:0] postscale_select;  // Bits 6:3
    logic       timer_run_bit;     // Bit 2
    logic [1:0] prescale_select;   // Bits 1:0
  } pmt_ctrl_t;

  // Timer event outputs carried together
  typedef struct packed {
    logic match_pulse;     // Unscaled match, one core cycle
    logic shift_clk;       // Toggles on each match
  } pmt_evt_t;

endpackage : pmt_pkg

// ===== tb/pmt_timer_tb.sv
// Self-checking testbench for the periodic match timer over its APB registers.
`timescale 1ns/1ps
`default_nettype none

module pmt_timer_tb
  import pmt_pkg::*;
;
  localparam int IDV = PMT_INSTR_CYCLES;

  logic        core_clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  pmt_evt_t    timer_evt;
  int          checks;
  int          miscompares;
  logic [31:0] rd_d;
  logic        rd_e;

  pmt_timer #(.INSTR_DIV(IDV)) u_pmt_timer (
    .core_clk  (core_clk),
    .srst      (srst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .irq       (irq),
    .timer_evt (timer_evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  always #2 core_clk = ~core_clk;

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // One comparison, reported at once on mismatch
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  ////////////////////////////////////////////////////////////////////////////
  // APB transfer; entered right after a rising edge, leaves one edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 50)
      cmp(32'h0000_0001, 32'h0000_0000, "pready timeout");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, rd_d, rd_e);
  endtask : wreg

  // Read a register, compare data and error response
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic err);
    apb(1'b0, a, 32'h0000_0000, rd_d, rd_e);
    cmp(rd_d, {24'h00_0000, exp}, "read data");
    cmp({31'h0, rd_e}, {31'h0, err}, "pslverr");
  endtask : rchk

  // Cycles until the next match pulse
  task automatic wait_pulse(output int n);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (timer_evt.match_pulse !== 1'b1 && n < 2000);
  endtask : wait_pulse

  // Match pulses seen until the interrupt line rises
  task automatic cnt_irq(output int n);
    int k;
    n = 0;
    k = 0;
    while (irq !== 1'b1 && k < 5000)
    begin
      @(posedge core_clk);
      k++;
      if (timer_evt.match_pulse === 1'b1)
        n++;
    end
  endtask : cnt_irq

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rchk(PMT_COUNT_ADDR, 8'h00, 1'b0);
    rchk(PMT_PERIOD_ADDR, 8'hFF, 1'b0);
    rchk(PMT_CONTROL_ADDR, 8'h00, 1'b0);
    rchk(PMT_STATUS_ADDR, 8'h00, 1'b0);
    rchk(PMT_MASK_ADDR, 8'h00, 1'b0);
  endtask : t_reset

  task automatic t_regs();
    wreg(PMT_PERIOD_ADDR, 8'hA5);
    rchk(PMT_PERIOD_ADDR, 8'hA5, 1'b0);
    wreg(PMT_COUNT_ADDR, 8'h5A);
    rchk(PMT_COUNT_ADDR, 8'h5A, 1'b0);
    wreg(PMT_CONTROL_ADDR, 8'hFB);
    rchk(PMT_CONTROL_ADDR, 8'h7B, 1'b0);
    wreg(PMT_COUNT_ADDR, 8'h09);
    wreg(PMT_CONTROL_ADDR, 8'h03);
    rchk(PMT_COUNT_ADDR, 8'h09, 1'b0);
    repeat (40) @(posedge core_clk);
    rchk(PMT_COUNT_ADDR, 8'h09, 1'b0);
    rchk(8'h14, 8'h00, 1'b1);
  endtask : t_regs

  // Match spacing for every prescale code, shift clock toggling per match
  task automatic t_presc();
    int   n;
    int   dv;
    logic sh;
    wreg(PMT_PERIOD_ADDR, 8'h03);
    wreg(PMT_COUNT_ADDR, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      dv = (k == 0) ? 1 : ((k == 1) ? 4 : 16);
      wreg(PMT_CONTROL_ADDR, {6'b000001, k[1:0]});
      wait_pulse(n);
      sh = timer_evt.shift_clk;
      wait_pulse(n);
      cmp(32'(n), 32'(4 * IDV * dv), "match spacing");
      cmp({31'h0, timer_evt.shift_clk}, {31'h0, ~sh}, "shift clock");
    end
  endtask : t_presc

  // Matches per interrupt, latching, masking and clearing of the flag
  task automatic t_post();
    int n;
    logic [3:0] ps [3] = '{4'h0, 4'h4, 4'hF};
    wreg(PMT_MASK_ADDR, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      wreg(PMT_CONTROL_ADDR, 8'h00);
      rchk(PMT_STATUS_ADDR, 8'h01, 1'b0);
      rchk(PMT_STATUS_ADDR, 8'h00, 1'b0);
      wreg(PMT_CONTROL_ADDR, {1'b0, ps[i], 3'b100});
      cnt_irq(n);
      cmp(32'(n), 32'(ps[i]) + 32'd1, "matches per interrupt");
    end
    wreg(PMT_CONTROL_ADDR, 8'h00);
    repeat (30) @(posedge core_clk);
    cmp({31'h0, irq}, 32'h1, "flag held");
    wreg(PMT_MASK_ADDR, 8'h00);
    repeat (2) @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0, "masked interrupt");
    rchk(PMT_STATUS_ADDR, 8'h01, 1'b0);
    wreg(PMT_MASK_ADDR, 8'h01);
    repeat (3) @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0, "flag cleared by read");
  endtask : t_post

  // A count write in mid-sequence restarts the postscaler
  task automatic t_clear();
    int n;
    wreg(PMT_CONTROL_ADDR, 8'h0C);
    wait_pulse(n);
    wreg(PMT_COUNT_ADDR, 8'h00);
    cnt_irq(n);
    cmp(32'(n), 32'd2, "postscaler restart");
    wreg(PMT_CONTROL_ADDR, 8'h00);
  endtask : t_clear

  // A reset in mid-run, with the timer counting and the interrupt up
  task automatic t_rst();
    wreg(PMT_PERIOD_ADDR, 8'h40);
    wreg(PMT_CONTROL_ADDR, 8'h04);
    repeat (100) @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0, "irq after mid-run reset");
    rchk(PMT_COUNT_ADDR, 8'h00, 1'b0);
    rchk(PMT_PERIOD_ADDR, 8'hFF, 1'b0);
    rchk(PMT_CONTROL_ADDR, 8'h00, 1'b0);
  endtask : t_rst

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    core_clk    = 1'b0;
    srst        = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    checks      = 0;
    miscompares = 0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    cmp({31'h0, irq}, 32'h0, "irq after reset");
    t_reset();
    t_regs();
    t_presc();
    t_post();
    t_clear();
    t_rst();
    test_done();
  end

  // Watchdog against a hang
  initial
  begin
    #200000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

endmodule : pmt_timer_tb

`default_nettype wire
